// *** shared/tac_pkg.sv ***
// Summary of operation
// - Enable bit starts and stops counting
// - Stop-in-idle halts timer during idle
// - Write disable ignores count writes while pending
// - Write disable clear allows back-to-back writes
// - Pending flag high during async write
// - Pending flag reads zero in sync mode
// - Select field picks external clock source
// - Gate enable only with internal clock
// - Prescale field divides by 1/8/64/256
// - Sync bit chooses external input synchronising
// - Source bit picks external or internal clock
// - Unimplemented control bits read as zero
package tac_pkg;

  // ==========================================================
  // Register map
  localparam logic [3:0] TAC_ADDR_CONTROL = 4'h0;
  localparam logic [3:0] TAC_ADDR_COUNT = 4'h4;
  localparam logic [31:0] TAC_CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] TAC_CONTROL_WMASK = 32'h0000_B3B6;

  // ==========================================================
  // Control fields
  localparam int TAC_BIT_ON = 15;
  localparam int TAC_BIT_STOP_IDLE = 13;
  localparam int TAC_BIT_WDIS = 12;
  localparam int TAC_BIT_WIP = 11;
  localparam int TAC_BIT_ECS = 8;
  localparam int TAC_BIT_GATE = 7;
  localparam int TAC_BIT_PS = 4;
  localparam int TAC_BIT_SYNC = 2;
  localparam int TAC_BIT_CS = 1;

  localparam logic [1:0] TAC_ECS_SEC_OSC = 2'h0;
  localparam logic [1:0] TAC_ECS_PIN = 2'h1;
  localparam logic [1:0] TAC_ECS_RC_OSC = 2'h2;

  // Cycles an asynchronous count write takes to land.
  localparam logic [1:0] TAC_WRITE_CYCLES = 2'h3;

  typedef struct packed {
    logic on;
    logic stop_idle;
    logic wdis;
    logic [1:0] ecs;
    logic gate;
    logic [1:0] ps;
    logic sync;
    logic cs;
  } tac_ctrl_t;

  typedef struct packed {
    logic secondary_osc;
    logic timer_clock_pin;
    logic low_power_rc_osc;
  } tac_ext_t;

  typedef enum logic [1:0] {
    TAC_WR_IDLE = 2'b00,
    TAC_WR_BUSY = 2'b01
  } tac_wr_state_t;

endpackage

// *** hw/tac_prescaler.sv ***
`timescale 1ns/1ps
module tac_prescaler
  import tac_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Control
  input wire logic clear,
  input wire logic edge_in,
  input wire logic [1:0] ps,
  // Result
  output logic tick
);
  logic [7:0] div_r;
  logic [7:0] div_nxt;
  logic [7:0] limit;

  always_comb begin
    case (ps)
      2'h0: limit = 8'h00;
      2'h1: limit = 8'h07;
      2'h2: limit = 8'h3F;
      default: limit = 8'hFF;
    endcase
    div_nxt = div_r;
    tick = 1'b0;
    if (clear) begin
      div_nxt = 8'h00;
    end else if (edge_in) begin
      if (div_r >= limit) begin
        div_nxt = 8'h00;
        tick = 1'b1;
      end else begin
        div_nxt = div_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_nxt;
    end
  end
endmodule

// *** hw/tac_timer.sv ***
`timescale 1ns/1ps
module tac_timer
  import tac_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Device and clock inputs
  input wire logic idle,
  input wire logic gate_in,
  input wire tac_ext_t ext_in,
  // Status
  output logic [15:0] count_out
);
  // ==========================================================
  // Declarations
  tac_ctrl_t ctrl_r;
  tac_ctrl_t ctrl_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [15:0] wbuf_r;
  logic [15:0] wbuf_nxt;
  tac_wr_state_t wst_r;
  tac_wr_state_t wst_nxt;
  logic [1:0] wcnt_r;
  logic [1:0] wcnt_nxt;
  logic s1_r;
  logic s1_nxt;
  logic s2_r;
  logic s2_nxt;
  logic s3_r;
  logic s3_nxt;
  logic u_r;
  logic u_nxt;
  logic gate_r;
  logic gate_nxt;
  logic ext_raw;
  logic ext_edge;
  logic src_edge;
  logic run;
  logic tick;
  logic async_mode;
  logic wip;
  logic ctrl_wr;
  logic count_wr;
  logic count_accept;
  logic load_due;

  // ==========================================================
  // Helper functions
  // One decode serves the register writes and the checks below.
  function automatic logic strobe_at(input logic strobe, input logic [3:0] a,
      input logic [3:0] target);
    return strobe && (a == target);
  endfunction

  // The reserved select code yields a constant low level, so it never clocks.
  function automatic logic pick_source(input logic [1:0] code, input tac_ext_t src);
    logic lvl;
    case (code)
      TAC_ECS_SEC_OSC: lvl = src.secondary_osc;
      TAC_ECS_PIN: lvl = src.timer_clock_pin;
      TAC_ECS_RC_OSC: lvl = src.low_power_rc_osc;
      default: lvl = 1'b0;
    endcase
    return lvl;
  endfunction

  // Unimplemented positions stay zero because the word starts cleared.
  function automatic logic [31:0] pack_control(input tac_ctrl_t c, input logic pend);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[TAC_BIT_ON] = c.on;
    w[TAC_BIT_STOP_IDLE] = c.stop_idle;
    w[TAC_BIT_WDIS] = c.wdis;
    w[TAC_BIT_WIP] = pend;
    w[TAC_BIT_ECS +: 2] = c.ecs;
    w[TAC_BIT_GATE] = c.gate;
    w[TAC_BIT_PS +: 2] = c.ps;
    w[TAC_BIT_SYNC] = c.sync;
    w[TAC_BIT_CS] = c.cs;
    return w;
  endfunction

  // ==========================================================
  // Decodes and mode
  assign ctrl_wr = strobe_at(wr, addr, TAC_ADDR_CONTROL);
  assign count_wr = strobe_at(wr, addr, TAC_ADDR_COUNT);
  // Only an unsynchronised external clock makes count writes asynchronous.
  assign async_mode = ctrl_r.cs & ~ctrl_r.sync;
  assign wip = async_mode & (wst_r == TAC_WR_BUSY);

  // ==========================================================
  // Clock source sampling
  assign ext_raw = pick_source(ctrl_r.ecs, ext_in);

  always_comb begin
    s1_nxt = ext_raw;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    u_nxt = ext_raw;
    gate_nxt = gate_in;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      u_r <= 1'b0;
      gate_r <= 1'b0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      u_r <= u_nxt;
      gate_r <= gate_nxt;
    end
  end

  // Synchronised edge uses the second stage onward; unsynchronised
  // uses a single sample, which is faster but may miss glitchy edges.
  assign ext_edge = ctrl_r.sync ? (s2_r & ~s3_r) : (ext_raw & ~u_r);
  assign src_edge = ctrl_r.cs ? ext_edge : 1'b1;
  assign run = ctrl_r.on & ~(ctrl_r.stop_idle & idle)
             & (ctrl_r.cs | ~ctrl_r.gate | gate_r);

  // ==========================================================
  // Prescaler
  tac_prescaler tac_prescaler_inst (
    .clock(clock),
    .resetn(resetn),
    .clear(~ctrl_r.on),
    .edge_in(src_edge & run),
    .ps(ctrl_r.ps),
    .tick(tick)
  );

  // ==========================================================
  // Control register
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (ctrl_wr) begin
      ctrl_nxt.on = wdata[TAC_BIT_ON];
      ctrl_nxt.stop_idle = wdata[TAC_BIT_STOP_IDLE];
      ctrl_nxt.wdis = wdata[TAC_BIT_WDIS];
      ctrl_nxt.ecs = wdata[TAC_BIT_ECS +: 2];
      ctrl_nxt.gate = wdata[TAC_BIT_GATE];
      ctrl_nxt.ps = wdata[TAC_BIT_PS +: 2];
      ctrl_nxt.sync = wdata[TAC_BIT_SYNC];
      ctrl_nxt.cs = wdata[TAC_BIT_CS];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ==========================================================
  // Asynchronous count write
  // A refused write leaves the pending value and its countdown untouched.
  assign count_accept = count_wr && async_mode
                      && !(ctrl_r.wdis && wst_r == TAC_WR_BUSY);
  assign load_due = (wst_r == TAC_WR_BUSY) && (wcnt_r == 2'h1);

  always_comb begin
    wbuf_nxt = wbuf_r;
    wst_nxt = wst_r;
    wcnt_nxt = wcnt_r;
    if (wst_r == TAC_WR_BUSY) begin
      wcnt_nxt = wcnt_r - 2'h1;
      if (load_due) begin
        wst_nxt = TAC_WR_IDLE;
      end
    end
    if (count_accept) begin
      wbuf_nxt = wdata[15:0];
      wst_nxt = TAC_WR_BUSY;
      wcnt_nxt = TAC_WRITE_CYCLES;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wbuf_r <= 16'h0000;
      wst_r <= TAC_WR_IDLE;
      wcnt_r <= 2'h0;
    end else begin
      wbuf_r <= wbuf_nxt;
      wst_r <= wst_nxt;
      wcnt_r <= wcnt_nxt;
    end
  end

  // ==========================================================
  // Counter
  // A landing write wins over a tick in the same cycle, trading one lost
  // count for a value that always matches what software wrote.
  always_comb begin
    count_nxt = count_r;
    if (tick) begin
      count_nxt = count_r + 16'h0001;
    end
    if (load_due) begin
      count_nxt = wbuf_r;
    end
    if (count_wr && !async_mode) begin
      count_nxt = wdata[15:0];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count_r <= 16'h0000;
    end else begin
      count_r <= count_nxt;
    end
  end

  // ==========================================================
  // Read path
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (rd) begin
      case (addr)
        TAC_ADDR_CONTROL: rdata_nxt = pack_control(ctrl_r, wip);
        TAC_ADDR_COUNT: rdata_nxt = {16'h0000, count_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= TAC_CONTROL_RESET;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;
  assign count_out = count_r;

  // ==========================================================
  // Checks
  a_off_holds: assert property (@(posedge clock) disable iff (!resetn)
    !ctrl_r.on && wst_r == TAC_WR_IDLE && !wr |=> $stable(count_r))
    else $error("count moved while disabled");
  a_idle_stop: assert property (@(posedge clock) disable iff (!resetn)
    ctrl_r.on && ctrl_r.stop_idle && idle |-> !tick)
    else $error("tick during idle stop");
  a_wdis_block: assert property (@(posedge clock) disable iff (!resetn)
    wr && addr == TAC_ADDR_COUNT && async_mode && ctrl_r.wdis && wst_r == TAC_WR_BUSY
    |=> $stable(wbuf_r))
    else $error("write not ignored");
  a_b2b_ok: assert property (@(posedge clock) disable iff (!resetn)
    wr && addr == TAC_ADDR_COUNT && async_mode && !ctrl_r.wdis
    |=> wbuf_r == $past(wdata[15:0]) && wst_r == TAC_WR_BUSY)
    else $error("back-to-back write lost");
  a_wip_done: assert property (@(posedge clock) disable iff (!resetn)
    count_accept ##1 (!count_wr) [*3] |=> wst_r == TAC_WR_IDLE)
    else $error("async write never completes");
  a_wip_flag: assert property (@(posedge clock) disable iff (!resetn)
    wip && rd && addr == TAC_ADDR_CONTROL |=> rdata_r[TAC_BIT_WIP])
    else $error("pending flag not shown");
  a_load_value: assert property (@(posedge clock) disable iff (!resetn)
    load_due && !(count_wr && !async_mode) |=> count_r == $past(wbuf_r))
    else $error("pending value not loaded");
  a_fast_tick: assert property (@(posedge clock) disable iff (!resetn)
    ctrl_r.on && !ctrl_r.cs && !ctrl_r.gate && ctrl_r.ps == 2'h0
    && !(ctrl_r.stop_idle && idle) |-> tick)
    else $error("no tick at one to one prescale");
  a_reserved_src: assert property (@(posedge clock) disable iff (!resetn)
    (ctrl_r.cs && ctrl_r.ecs == 2'h3) [*4] |-> !ext_edge)
    else $error("reserved source produced an edge");
  a_gate_ignored: assert property (@(posedge clock) disable iff (!resetn)
    ctrl_r.on && ctrl_r.cs && ctrl_r.gate && ctrl_r.ps == 2'h0
    && !(ctrl_r.stop_idle && idle) && ext_edge |-> tick)
    else $error("gate blocked external clock");
  a_rdata_quiet: assert property (@(posedge clock) disable iff (!resetn)
    !rd |=> rdata_r == 32'h0000_0000)
    else $error("read data without a read");
  a_wip_sync: assert property (@(posedge clock) disable iff (!resetn)
    rd && addr == TAC_ADDR_CONTROL && !async_mode |=> !rdata_r[TAC_BIT_WIP])
    else $error("pending flag set in sync mode");
  a_gate_hold: assert property (@(posedge clock) disable iff (!resetn)
    ctrl_r.on && !ctrl_r.cs && ctrl_r.gate && !gate_r |-> !tick)
    else $error("count advanced with gate low");
  a_upper_zero: assert property (@(posedge clock) disable iff (!resetn)
    rdata_r[31:16] == 16'h0000)
    else $error("upper bits not zero");
  a_tick_inc: assert property (@(posedge clock) disable iff (!resetn)
    tick && wst_r == TAC_WR_IDLE && !wr |=> count_r == $past(count_r) + 16'h0001)
    else $error("tick did not increment");
  c_async_wr: cover property (@(posedge clock) wip);
  c_gated: cover property (@(posedge clock) tick && ctrl_r.gate && !ctrl_r.cs);
  c_ext_tick: cover property (@(posedge clock) tick && ctrl_r.cs);
  c_wr_refused: cover property (@(posedge clock)
    count_wr && async_mode && ctrl_r.wdis && wst_r == TAC_WR_BUSY);
  c_idle_halt: cover property (@(posedge clock) ctrl_r.on && ctrl_r.stop_idle && idle);
endmodule

// *** tb/tac_clock_model.sv ***
`timescale 1ns/1ps
module tac_clock_model
  import tac_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Source levels
  output tac_ext_t ext_in
);
  // ==========================================================
  // Free-running sources
  // Periods of 4, 6 and 10 cycles divide 60, so any window that is a
  // multiple of 60 holds an exact number of rising edges of each.
  logic [7:0] phase_r;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      phase_r <= 8'h00;
    end else begin
      phase_r <= (phase_r == 8'h3B) ? 8'h00 : phase_r + 8'h01;
    end
  end
  assign ext_in.secondary_osc = (phase_r % 4) < 2;
  assign ext_in.timer_clock_pin = (phase_r % 6) < 3;
  assign ext_in.low_power_rc_osc = (phase_r % 10) < 5;
endmodule

// *** tb/type_a_timer_control_bench.sv ***
`timescale 1ns/1ps
module type_a_timer_control_bench
  import tac_pkg::*;
;
  logic clock, resetn, wr, rd, idle, gate_in;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  logic [15:0] count_out;
  tac_ext_t ext_in;
  int n_errors = 0;
  int samples_checked = 0;
  int div[4] = '{1, 8, 64, 256};
  int edges[4] = '{30, 20, 12, 0};

  tac_clock_model tac_clock_model_inst(.clock(clock), .resetn(resetn), .ext_in(ext_in));
  tac_timer tac_timer_inst(.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .idle(idle), .gate_in(gate_in), .ext_in(ext_in),
    .count_out(count_out));

  // ==========================================================
  // Access tasks
  task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 check(rdata, exp);
  endtask
  // A count write followed at once by a second write or a read.
  task bb(input logic [3:0] a2, input logic [31:0] d1, input logic [31:0] d2, input logic rd2);
    @(posedge clock);
    addr <= TAC_ADDR_COUNT;
    wdata <= d1;
    wr <= 1'b1;
    @(posedge clock);
    addr <= a2;
    wdata <= d2;
    wr <= !rd2;
    rd <= rd2;
    @(posedge clock);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 if (rd2) check(rdata, d2);
  endtask
  task span(input int n, input logic [15:0] exp);
    logic [15:0] c0;
    repeat (8) @(posedge clock);
    #1 c0 = count_out;
    repeat (n) @(posedge clock);
    #1 check(count_out - c0, exp);
  endtask
  task stop_test;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================
  // Clock, watchdog and sequence
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    repeat (100000) @(posedge clock);
    n_errors++;
    stop_test;
  end
  initial begin
    resetn = 1'b0;
    addr = 4'h0;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    idle = 1'b0;
    gate_in = 1'b0;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    rd_reg(TAC_ADDR_CONTROL, 32'h0000_0000);
    rd_reg(TAC_ADDR_COUNT, 32'h0000_0000);
    rd_reg(4'h8, 32'h0000_0000);
    wr_reg(TAC_ADDR_CONTROL, 32'hFFFF_FFFF);
    rd_reg(TAC_ADDR_CONTROL, 32'h0000_B3B6);
    for (int i = 0; i < 4; i++) begin
      wr_reg(TAC_ADDR_CONTROL, 32'h0000_8000 | (i << 4));
      span(10 * div[i], 16'h000A);
    end
    wr_reg(TAC_ADDR_CONTROL, 32'h0000_0000);
    span(20, 16'h0000);
    @(posedge clock) idle <= 1'b1;
    wr_reg(TAC_ADDR_CONTROL, 32'h0000_A000);
    span(20, 16'h0000);
    wr_reg(TAC_ADDR_CONTROL, 32'h0000_8000);
    span(20, 16'h0014);
    @(posedge clock) idle <= 1'b0;
    wr_reg(TAC_ADDR_CONTROL, 32'h0000_8080);
    span(20, 16'h0000);
    @(posedge clock) gate_in <= 1'b1;
    span(20, 16'h0014);
    @(posedge clock) gate_in <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr_reg(TAC_ADDR_CONTROL, 32'h0000_8086 | (i << 8));
      span(120, edges[i]);
    end
    wr_reg(TAC_ADDR_CONTROL, 32'h0000_8102);
    span(120, 16'h0014);
    wr_reg(TAC_ADDR_CONTROL, 32'h0000_9302);
    bb(TAC_ADDR_COUNT, 32'h0000_1234, 32'h0000_5678, 1'b0);
    span(0, 16'h0000);
    check(count_out, 32'h0000_1234);
    bb(TAC_ADDR_CONTROL, 32'h0000_4321, 32'h0000_9B02, 1'b1);
    repeat (6) @(posedge clock);
    rd_reg(TAC_ADDR_CONTROL, 32'h0000_9302);
    wr_reg(TAC_ADDR_CONTROL, 32'h0000_8302);
    bb(TAC_ADDR_COUNT, 32'h0000_1111, 32'h0000_2222, 1'b0);
    span(0, 16'h0000);
    check(count_out, 32'h0000_2222);
    wr_reg(TAC_ADDR_CONTROL, 32'h0000_8306);
    bb(TAC_ADDR_CONTROL, 32'hFFFF_0ABC, 32'h0000_8306, 1'b1);
    rd_reg(TAC_ADDR_COUNT, 32'h0000_0ABC);
    stop_test;
  end
endmodule
